// [rtl/fts_pkg.sv]
// Shared constants and carrier types for the flow-through SRAM read and write control
package fts_pkg;
  localparam int ADDR_W = 21;
  localparam int DATA_W = 32;
  localparam int PAR_W = 4;
  localparam int LANE_W = 4;
  localparam int BURST_W = 2;
  localparam logic [1:0] BURST_STEP = 2'h1;
  localparam logic [1:0] BURST_ZERO = 2'h0;
  localparam logic TDO_RESET = 1'h0;

  typedef struct packed {
    logic clock_gate_n;
    logic select_low_a;
    logic select_high_b;
    logic select_low_c;
    logic advance_or_load;
    logic write_n;
    logic [LANE_W-1:0] byte_lane_select_n;
    logic [ADDR_W-1:0] addr;
  } fts_cmd_t;

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [PAR_W-1:0] parity_lines;
  } fts_word_t;

  typedef enum logic [3:0] {
    FTS_DESEL = 4'h1,
    FTS_READ = 4'h2,
    FTS_WRITE = 4'h4,
    FTS_SUSP = 4'h8
  } fts_state_t;
endpackage

// [rtl/fts_array.sv]
// Storage array with registered read port for the flow-through SRAM model
module fts_array #(
  parameter int AW = 8,
  parameter int DW = 36
) (
  input wire logic clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [DW-1:0] wr_data,
  input wire logic [DW-1:0] wr_mask,
  input wire logic rd_en,
  input wire logic [AW-1:0] rd_addr,
  output logic [DW-1:0] rd_data
);
  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= (mem[wr_addr] & ~wr_mask) | (wr_data & wr_mask);
    end
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule

// [rtl/fts_ctrl.sv]
// Flow-through SRAM control front end: input capture, burst, output enable
// Behaviour
// RULE1: Strap low linear, high interleaved burst
// RULE2: Test serial output changes on falling edge
// RULE3: Test inputs sampled on rising test clock
// RULE4: Synchronous inputs registered on rising clock
// RULE5: Clock gate high freezes all state; the test port registers on test_clk keep running
// RULE6: Selected load latches address; strobe picks type
// RULE7: Read starts on select, load, strobe high
// RULE8: Read data flows through without extra stage
// RULE9: Output enable plus control govern drivers
// RULE10: New operation accepted right after read
// RULE11: Any select inactive tristates outputs immediately
// RULE12: Host loads fresh address after deselect
// RULE13: Outputs forced off on write, emerge, deselect
// RULE14: Burst counter wraps two low address bits
module fts_ctrl #(
  parameter int ARRAY_AW = 8
) (
  input wire logic clk,
  input wire logic rst,
  input wire fts_pkg::fts_cmd_t cmd,
  input wire logic output_enable_n,
  input wire logic burst_mode,
  input wire fts_pkg::fts_word_t wr_word,
  input wire logic test_clk,
  input wire logic test_in,
  input wire logic test_mode,
  output fts_pkg::fts_word_t rd_word,
  output logic rd_oe,
  output logic test_out,
  output logic test_mode_seen
);
  localparam int WW = fts_pkg::DATA_W + fts_pkg::PAR_W;
  localparam int LW = WW / fts_pkg::LANE_W;

  fts_pkg::fts_state_t state;
  fts_pkg::fts_state_t next_state;
  logic [fts_pkg::ADDR_W-1:0] base_addr;
  logic [1:0] burst_cnt;
  logic [1:0] next_burst_cnt;
  logic was_desel;
  logic wr_pend;
  logic [fts_pkg::ADDR_W-1:0] wr_pend_addr;
  logic [fts_pkg::LANE_W-1:0] wr_pend_lanes;
  logic [WW-1:0] arr_q;
  logic [WW-1:0] lane_mask;
  logic [1:0] test_shift;

  // Inputs are taken synchronous; the clocked use below is the capture register [RULE4]
  wire active = ~cmd.clock_gate_n; // [RULE5]
  wire all_sel = ~cmd.select_low_a & cmd.select_high_b & ~cmd.select_low_c;
  wire do_load = active & ~cmd.advance_or_load & all_sel; // [RULE6]
  wire do_read = do_load & cmd.write_n; // [RULE7]
  wire do_write = do_load & ~cmd.write_n;
  wire do_desel = active & ~cmd.advance_or_load & ~all_sel; // [RULE11]
  // Burst continues only from a loaded access; after deselect host must load [RULE12]
  wire do_adv = active & cmd.advance_or_load & (state != fts_pkg::FTS_DESEL);
  wire [1:0] cnt_inc = burst_cnt + fts_pkg::BURST_STEP;
  wire [1:0] lin_lsb = base_addr[1:0] + next_burst_cnt;
  wire [1:0] int_lsb = base_addr[1:0] ^ next_burst_cnt;
  wire [1:0] burst_lsb = burst_mode ? int_lsb : lin_lsb; // [RULE1] [RULE14]
  wire [fts_pkg::ADDR_W-1:0] load_addr = cmd.addr;
  wire [fts_pkg::ADDR_W-1:0] seq_addr = {base_addr[fts_pkg::ADDR_W-1:2], burst_lsb};
  wire [fts_pkg::ADDR_W-1:0] acc_addr = do_load ? load_addr : seq_addr;
  wire rd_go = do_read | (do_adv & (state == fts_pkg::FTS_READ));
  wire wr_go = do_write | (do_adv & (state == fts_pkg::FTS_WRITE));
  wire emerging = was_desel & do_load;
  // Drivers off on write data phase, emerging and while deselected [RULE13]
  wire next_oe = rd_go & ~emerging & ~output_enable_n; // [RULE9]

  always_comb begin
    next_state = state;
    next_burst_cnt = burst_cnt;
    if (do_load) begin
      next_state = cmd.write_n ? fts_pkg::FTS_READ : fts_pkg::FTS_WRITE;
      next_burst_cnt = fts_pkg::BURST_ZERO;
    end else if (do_desel) begin
      next_state = fts_pkg::FTS_DESEL;
    end else if (do_adv) begin
      next_burst_cnt = cnt_inc; // [RULE14]
    end
  end

  genvar g;
  generate
    for (g = 0; g < fts_pkg::LANE_W; g++) begin : g_lane
      assign lane_mask[g*LW +: LW] = {LW{~wr_pend_lanes[g]}};
    end
  endgenerate

  // Array read is registered on the same edge: data flow through, no extra stage [RULE8]
  fts_array #(
    .AW(ARRAY_AW),
    .DW(WW)
  ) u_array (
    .clk(clk),
    .wr_en(wr_pend & active),
    .wr_addr(wr_pend_addr[ARRAY_AW-1:0]),
    .wr_data(wr_word),
    .wr_mask(lane_mask),
    .rd_en(rd_go),
    .rd_addr(acc_addr[ARRAY_AW-1:0]),
    .rd_data(arr_q)
  );

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= fts_pkg::FTS_DESEL;
      base_addr <= '0;
      burst_cnt <= fts_pkg::BURST_ZERO;
      was_desel <= 1'b1;
    end else if (active) begin // [RULE5]
      state <= next_state;
      burst_cnt <= next_burst_cnt;
      if (do_load) begin
        base_addr <= load_addr; // [RULE6]
      end
      was_desel <= do_desel | (was_desel & ~do_load);
    end
  end

  // Write data lands one edge after the command
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      wr_pend_addr <= '0;
      wr_pend_lanes <= '0;
    end else if (active) begin
      wr_pend <= wr_go;
      wr_pend_addr <= acc_addr;
      wr_pend_lanes <= cmd.byte_lane_select_n;
    end
  end

  // Back-to-back: a new command is decoded every active edge [RULE10]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_oe <= 1'b0;
    end else if (active) begin
      rd_oe <= next_oe; // [RULE11] [RULE13]
    end
  end

  assign rd_word = arr_q;

  // Test port: sample on rising, shift out on falling test clock
  always_ff @(posedge test_clk or posedge rst) begin
    if (rst) begin
      test_shift <= '0;
      test_mode_seen <= 1'b0;
    end else begin
      test_shift <= {test_shift[0], test_in}; // [RULE3]
      test_mode_seen <= test_mode; // [RULE3]
    end
  end

  always_ff @(negedge test_clk or posedge rst) begin
    if (rst) begin
      test_out <= fts_pkg::TDO_RESET;
    end else begin
      test_out <= test_shift[1]; // [RULE2]
    end
  end

  // Test output as seen at each rising test clock; a change made there shows at the fall
  logic test_out_at_rise;
  always_ff @(posedge test_clk or posedge rst) begin
    if (rst) begin
      test_out_at_rise <= fts_pkg::TDO_RESET;
    end else begin
      test_out_at_rise <= test_out;
    end
  end

  gate_hold_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    cmd.clock_gate_n |=> $stable(state) && $stable(base_addr) && $stable(burst_cnt))
    else $error("state moved while clock gated");
  gate_out_a: assert property (@(posedge clk) disable iff (rst) // [RULE5]
    cmd.clock_gate_n |=> $stable(rd_oe) && $stable(rd_word) && $stable(wr_pend))
    else $error("outputs moved while clock gated");
  load_addr_a: assert property (@(posedge clk) disable iff (rst) // [RULE6]
    do_load |=> base_addr == $past(cmd.addr) && burst_cnt == 2'h0)
    else $error("address not latched on load");
  read_start_a: assert property (@(posedge clk) disable iff (rst) // [RULE7]
    do_read |=> state == fts_pkg::FTS_READ)
    else $error("read not started");
  desel_off_a: assert property (@(posedge clk) disable iff (rst) // [RULE11]
    do_desel |=> !rd_oe && state == fts_pkg::FTS_DESEL)
    else $error("outputs driven after deselect");
  // An advance while deselected has no address to step from, so it must do nothing
  adv_desel_a: assert property (@(posedge clk) disable iff (rst) // [RULE12]
    (active && cmd.advance_or_load && state == fts_pkg::FTS_DESEL) |=>
      state == fts_pkg::FTS_DESEL && !rd_oe)
    else $error("advance accepted while deselected");
  emerge_off_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
    (active && was_desel && do_load) |=> !rd_oe)
    else $error("outputs driven on emerging cycle");
  write_off_a: assert property (@(posedge clk) disable iff (rst) // [RULE13]
    (active && wr_go) |=> !rd_oe)
    else $error("outputs driven in write data phase");
  oe_gate_a: assert property (@(posedge clk) disable iff (rst) // [RULE9]
    (active && output_enable_n) |=> !rd_oe)
    else $error("outputs on with output enable high");
  burst_wrap_a: assert property (@(posedge clk) disable iff (rst) // [RULE14]
    do_adv && !do_load |=> burst_cnt == $past(burst_cnt) + 2'h1)
    else $error("burst counter wrong step");
  burst_order_a: assert property (@(posedge clk) disable iff (rst) // [RULE1] [RULE14]
    do_adv |-> acc_addr[1:0] == (burst_mode ? (base_addr[1:0] ^ 2'(burst_cnt + 2'h1))
      : 2'(base_addr[1:0] + burst_cnt + 2'h1)))
    else $error("burst address out of order");
  burst_upper_a: assert property (@(posedge clk) disable iff (rst) // [RULE14]
    do_adv |-> acc_addr[fts_pkg::ADDR_W-1:2] == base_addr[fts_pkg::ADDR_W-1:2])
    else $error("burst left its group of four");
  back_read_a: assert property (@(posedge clk) disable iff (rst) // [RULE10]
    (do_read ##1 do_read) |=> state == fts_pkg::FTS_READ && !was_desel)
    else $error("back to back read refused");
  tdo_edge_a: assert property (@(negedge test_clk) disable iff (rst) // [RULE2]
    test_out == test_out_at_rise)
    else $error("test output changed on rising edge");
  tms_sample_a: assert property (@(posedge test_clk) disable iff (rst) // [RULE3]
    1'b1 |=> test_mode_seen == $past(test_mode))
    else $error("test mode not sampled on rising edge");
endmodule

// [tb/fts_host.sv]
// Host-side bus model: turns an operation code into the SRAM command word
module fts_host (
  input wire logic [1:0] op,
  input wire logic [7:0] addr,
  input wire logic gate_n,
  output fts_pkg::fts_cmd_t cmd
);
  timeunit 1ns;
  timeprecision 1ps;
  // Codes: 0 deselect, 1 read load, 2 write load, 3 advance
  assign cmd.clock_gate_n = gate_n;
  // Deselect drops one select only, so the others must not mask it
  assign cmd.select_low_a = (op == 2'h0);
  assign cmd.select_high_b = 1'h1;
  assign cmd.select_low_c = 1'h0;
  assign cmd.advance_or_load = (op == 2'h3);
  assign cmd.write_n = (op != 2'h2);
  assign cmd.byte_lane_select_n = 4'h0;
  assign cmd.addr = {13'h0, addr};
endmodule

// [tb/tb.sv]
// Self-checking bench for the flow-through SRAM control front end
`define CHK(n, e, s) begin n_tests++; if ((s) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %h got %h", n, e, s); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic m;
    logic oen;
    logic [1:0] op;
    logic [7:0] a;
    logic eo;
    logic [7:0] ea;
  } fts_row_t;
  logic clk = 0, rst = 0, oen = 0, mode = 0, tck = 0, tin = 0, tms = 0, gate_n = 0;
  logic [1:0] op = 0;
  logic [7:0] a = 0, wa = 0;
  fts_pkg::fts_cmd_t cmd;
  fts_pkg::fts_word_t wr, rd;
  logic rd_oe, tout, tseen;
  int miscompares = 0, n_tests = 0, cyc = 0;
  fts_row_t rows [18] = '{
    '{1'h0, 1'h0, 2'h0, 8'h00, 1'h0, 8'h00}, '{1'h0, 1'h0, 2'h2, 8'h04, 1'h0, 8'h00},
    '{1'h0, 1'h0, 2'h2, 8'h05, 1'h0, 8'h00}, '{1'h0, 1'h0, 2'h2, 8'h06, 1'h0, 8'h00},
    '{1'h0, 1'h0, 2'h2, 8'h07, 1'h0, 8'h00}, '{1'h0, 1'h0, 2'h1, 8'h05, 1'h1, 8'h05},
    '{1'h0, 1'h0, 2'h3, 8'h00, 1'h1, 8'h06}, '{1'h0, 1'h0, 2'h3, 8'h00, 1'h1, 8'h07},
    '{1'h0, 1'h0, 2'h3, 8'h00, 1'h1, 8'h04}, '{1'h0, 1'h0, 2'h1, 8'h06, 1'h1, 8'h06},
    '{1'h0, 1'h1, 2'h1, 8'h07, 1'h0, 8'h00}, '{1'h0, 1'h0, 2'h0, 8'h00, 1'h0, 8'h00},
    '{1'h0, 1'h0, 2'h1, 8'h04, 1'h0, 8'h00}, '{1'h0, 1'h0, 2'h3, 8'h00, 1'h1, 8'h05},
    '{1'h1, 1'h0, 2'h1, 8'h06, 1'h1, 8'h06}, '{1'h1, 1'h0, 2'h3, 8'h00, 1'h1, 8'h07},
    '{1'h1, 1'h0, 2'h3, 8'h00, 1'h1, 8'h04}, '{1'h1, 1'h0, 2'h3, 8'h00, 1'h1, 8'h05}};
  always #12.5 clk = ~clk;
  fts_host host (.op(op), .addr(a), .gate_n(gate_n), .cmd(cmd));
  fts_ctrl dut (.clk(clk), .rst(rst), .cmd(cmd), .output_enable_n(oen), .burst_mode(mode),
    .wr_word(wr), .test_clk(tck), .test_in(tin), .test_mode(tms), .rd_word(rd),
    .rd_oe(rd_oe), .test_out(tout), .test_mode_seen(tseen));
  // Data tied to its address so any misrouted read shows up
  function automatic fts_pkg::fts_word_t wd(input logic [7:0] x);
    return {8'hA5, x, 8'h3C, x, x[3:0] ^ 4'h9};
  endfunction
  assign wr = wd(wa);
  task automatic finish_test();
    $display("tests %0d miscompares %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic step(input logic [1:0] o, input logic [7:0] x);
    op = o;
    a = x;
    @(negedge clk);
  endtask
  task automatic tk(input logic b);
    tin = b;
    tms = b;
    @(negedge clk);
    tck = 1;
    @(negedge clk);
    tck = 0;
    @(negedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 400) begin
      miscompares++;
      finish_test();
    end
  end
  initial begin
    // A real rising edge on reset, so the test clock domain is cleared as well
    #1 rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    foreach (rows[i]) begin
      // Write data rides with the command after its write load
      wa = (i > 0 && rows[i-1].op == 2'h2) ? rows[i-1].a : 8'h00;
      mode = rows[i].m;
      oen = rows[i].oen;
      step(rows[i].op, rows[i].a);
      `CHK("rd_oe", rows[i].eo, rd_oe)
      if (rows[i].eo) `CHK("rd_word", wd(rows[i].ea), rd)
    end
    gate_n = 1;
    repeat (3) begin
      step(2'h3, 8'h00);
      `CHK("gated rd_word", wd(8'h05), rd)
      `CHK("gated rd_oe", 1'h1, rd_oe)
    end
    gate_n = 0;
    step(2'h3, 8'h00);
    `CHK("resumed rd_word", wd(8'h06), rd)
    repeat (3) tk(1'h1);
    `CHK("test_out", 1'h1, tout)
    `CHK("test_mode_seen", 1'h1, tseen)
    repeat (3) tk(1'h0);
    `CHK("test_out", 1'h0, tout)
    `CHK("test_mode_seen", 1'h0, tseen)
    repeat (3) tk(1'h1);
    rst = 1;
    #1;
    `CHK("reset rd_oe", 1'h0, rd_oe)
    `CHK("reset test_out", 1'h0, tout)
    `CHK("reset test_mode_seen", 1'h0, tseen)
    @(negedge clk);
    rst = 0;
    step(2'h1, 8'h04);
    `CHK("post reset rd_oe", 1'h0, rd_oe)
    step(2'h3, 8'h00);
    `CHK("post reset adv rd_oe", 1'h1, rd_oe)
    `CHK("post reset rd_word", wd(8'h05), rd)
    step(2'h0, 8'h00);
    `CHK("deselect rd_oe", 1'h0, rd_oe)
    step(2'h3, 8'h00);
    `CHK("advance after deselect rd_oe", 1'h0, rd_oe)
    step(2'h1, 8'h07);
    `CHK("reload rd_oe", 1'h0, rd_oe)
    step(2'h3, 8'h00);
    `CHK("reload rd_word", wd(8'h06), rd)
    finish_test();
  end
endmodule
